// ===== hdl/i2c_bridge_pkg.sv
// Constants and types shared by the I2C control bridge and its host controller
// How it works
// - Pass-through on forwards remote-bound transactions
// - Pass-through off forwards only alias-matched addresses to remote bus
// - Hold SCL low on ninth clock while bridging
// - Never clock host bus, release after remote answers
// - Host master waits while SCL is stretched
// - Own address from strap: 58, 59, 5A, 5D
// - Strap decode yields exactly one of four
// - Alias match swaps in target slave identifier
// - Sensor mode offers eight alias mappings
// - Display mode offers a single alias
// - Host keeps its own alias bookkeeping
// - Remote side acts as bus master
// - Host-facing side acts as bus slave
// - Host transactions carried across to remote bus
// - Alias access reaches slave at target address
// - ID select picks strap or programmed address
// - Slave runs at bus rates to 400 kbps
package i2c_bridge_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int I2C_MAX_BPS = 400_000;
    localparam int QUARTER_CYC = (CLK_HZ + 4 * I2C_MAX_BPS - 1) / (4 * I2C_MAX_BPS);
    localparam logic [6:0] STRAP_ADDR0 = 7'h58;
    localparam logic [6:0] STRAP_ADDR1 = 7'h59;
    localparam logic [6:0] STRAP_ADDR2 = 7'h5a;
    localparam logic [6:0] STRAP_ADDR3 = 7'h5d;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam int ALIAS_SENSOR = 8;
    localparam int ALIAS_DISPLAY = 1;
    localparam logic [8:0] TX_READ = 9'h1ff;
    localparam logic [3:0] BITS_BYTE_ACK = 4'h9;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] BITS_ACK = 4'h1;
    localparam logic [3:0] BITS_NONE = 4'h0;
    localparam logic [11:0] REG_CMD = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam int CMD_START_BIT = 8;
    localparam int CMD_STOP_BIT = 9;
    localparam int CMD_READ_BIT = 10;
    localparam int CMD_NACK_BIT = 11;
    localparam int CMD_SKIP_BIT = 12;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_NACK_BIT = 1;
    localparam int ST_RX_LSB = 8;

    typedef enum logic [3:0] {
        E_IDLE = 4'h1,
        E_START = 4'h2,
        E_BIT = 4'h4,
        E_STOP = 4'h8
    } eng_state_t;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_RECV = 7'h02,
        S_ACK = 7'h04,
        S_SEND = 7'h08,
        S_HW = 7'h10,
        S_HA = 7'h20,
        S_HR = 7'h40
    } slv_state_t;
endpackage

// ===== hdl/i2c_link_if.sv
// Open-drain I2C link between the host controller and the bridge
interface i2c_link_if;
    logic host_scl_out;
    logic host_scl_oe;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_scl_out;
    logic dev_scl_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Wired-AND with pull-up
    assign scl = ~(host_scl_oe & ~host_scl_out) & ~(dev_scl_oe & ~dev_scl_out);
    assign sda = ~(host_sda_oe & ~host_sda_out) & ~(dev_sda_oe & ~dev_sda_out);

    modport host (
        output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe,
        input scl, sda
    );
    modport dev (
        output dev_scl_out, dev_scl_oe, dev_sda_out, dev_sda_oe,
        input scl, sda
    );
endinterface

// ===== hdl/i2c_bridge_dev.sv
// Bridge end: host-facing slave, alias remap and remote bus master
module i2c_bit_engine
    import i2c_bridge_pkg::*;
    #(parameter int QUARTER = QUARTER_CYC)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Command
    input wire logic go,
    input wire logic do_start,
    input wire logic do_stop,
    input wire logic [8:0] tx,
    input wire logic [3:0] nbits,
    output logic idle,
    output logic done,
    output logic [8:0] rx,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_oe,
    output logic sda_oe
);
    logic scl_m, scl_s, sda_m, sda_s;
    logic [15:0] div_q;
    eng_state_t st_q;
    logic [1:0] ph_q;
    logic [8:0] tx_q;
    logic [8:0] rx_q;
    logic [3:0] n_q;
    logic stop_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic done_q;
    wire tick = (div_q == 16'(QUARTER - 1));
    // Phase 2 follows a clock release and waits while a slave stretches
    wire step = tick & ((ph_q != 2'h2) | scl_s);

    assign idle = (st_q == E_IDLE);
    assign done = done_q;
    assign rx = rx_q;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {scl_m, scl_s, sda_m, sda_s} <= 4'hf;
            div_q <= 16'h0000;
        end
        else
        begin
            {scl_m, scl_s, sda_m, sda_s} <= {scl_in, scl_m, sda_in, sda_m};
            div_q <= tick ? 16'h0000 : div_q + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= E_IDLE;
            ph_q <= 2'h0;
            tx_q <= 9'h000;
            rx_q <= 9'h000;
            n_q <= 4'h0;
            stop_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            unique case (st_q)
                E_IDLE:
                    if (go)
                    begin
                        tx_q <= tx;
                        n_q <= nbits;
                        stop_q <= do_stop;
                        rx_q <= 9'h000;
                        ph_q <= 2'h0;
                        st_q <= do_start ? E_START : E_BIT;
                    end
                E_START:
                    if (step)
                    begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: sda_oe_q <= 1'b0;
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b1;
                            default:
                            begin
                                scl_oe_q <= 1'b1;
                                st_q <= E_BIT;
                            end
                        endcase
                    end
                E_BIT:
                    if (step && ph_q == 2'h0 && n_q == 4'h0)
                    begin
                        st_q <= stop_q ? E_STOP : E_IDLE;
                        done_q <= ~stop_q;
                    end
                    else if (step)
                    begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: sda_oe_q <= ~tx_q[8];
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: rx_q <= {rx_q[7:0], sda_s};
                            default:
                            begin
                                scl_oe_q <= 1'b1;
                                tx_q <= {tx_q[7:0], 1'b1};
                                n_q <= n_q - 4'h1;
                            end
                        endcase
                    end
                E_STOP:
                    if (step)
                    begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: sda_oe_q <= 1'b1;
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b0;
                            default:
                            begin
                                st_q <= E_IDLE;
                                done_q <= 1'b1;
                            end
                        endcase
                    end
                default: st_q <= E_IDLE;
            endcase
        end
    end
endmodule

module i2c_bridge_dev
    import i2c_bridge_pkg::*;
    #(parameter int ALIAS_MAX = ALIAS_SENSOR)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Host-facing link
    i2c_link_if.dev link,
    // Remote bus
    input wire logic rem_scl_in,
    output logic rem_scl_out,
    output logic rem_scl_oe,
    input wire logic rem_sda_in,
    output logic rem_sda_out,
    output logic rem_sda_oe,
    // Configuration
    input wire logic [1:0] address_strap_pin,
    input wire logic id_select,
    input wire logic [6:0] device_id,
    input wire logic pass_through_en,
    input wire logic display_mode,
    input wire logic [ALIAS_MAX-1:0] alias_valid,
    input wire logic [ALIAS_MAX*7-1:0] alias_id,
    input wire logic [ALIAS_MAX*7-1:0] target_slave_identifier,
    // Status
    output logic [6:0] own_addr,
    output logic bridge_busy
);
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic [1:0] strap_m, strap_s, strap_cnt_q;
    logic strap_taken_q;
    logic [6:0] strap_addr_q;
    logic [6:0] own_addr_q;
    logic busy_q;
    slv_state_t st_q;
    logic [3:0] bitcnt_q;
    logic [7:0] shift_q, rdata_q;
    logic addr_byte_q, reading_q, fwd_q, host_ack_q, need_ack_q;
    logic scl_hold_q, scl_hold_p, sda_drv_q;
    logic remote_open_q, stop_pend_q, op_pend_q, op_busy_q, op_start_q;
    logic [8:0] op_tx_q;
    logic [3:0] op_n_q;
    logic eng_idle, eng_done;
    logic [8:0] eng_rx;
    logic alias_hit;
    logic [6:0] alias_tgt;

    wire rise = scl_s & ~scl_p;
    wire fall = ~scl_s & scl_p;
    wire start_ev = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_ev = scl_s & scl_p & ~sda_p & sda_s;
    wire [6:0] rx_addr = shift_q[7:1];
    // Exactly one of four strap addresses
    wire [6:0] strap_dec = (strap_s == 2'h0) ? STRAP_ADDR0 :
                           (strap_s == 2'h1) ? STRAP_ADDR1 :
                           (strap_s == 2'h2) ? STRAP_ADDR2 : STRAP_ADDR3;
    wire is_own = (rx_addr == own_addr_q);
    wire fwd_ok = alias_hit | pass_through_en;
    wire [6:0] fwd_addr = alias_hit ? alias_tgt : rx_addr;
    wire alias_lim_one = display_mode;
    wire go_stop = stop_pend_q & eng_idle;
    wire go_op = op_pend_q & eng_idle & ~stop_pend_q;
    wire op_done = eng_done & op_busy_q;

    assign link.dev_scl_out = 1'b0;
    assign link.dev_sda_out = 1'b0;
    // Release SCL one cycle after SDA settles
    assign link.dev_scl_oe = scl_hold_q | scl_hold_p;
    assign link.dev_sda_oe = sda_drv_q;
    assign rem_scl_out = 1'b0;
    assign rem_sda_out = 1'b0;
    assign own_addr = own_addr_q;
    assign bridge_busy = busy_q;

    // Alias lookup, lowest entry wins
    always_comb
    begin
        alias_hit = 1'b0;
        alias_tgt = 7'h00;
        for (int i = ALIAS_MAX - 1; i >= 0; i--)
        begin
            if (alias_valid[i] && (i == 0 || !alias_lim_one) &&
                alias_id[i*7 +: 7] == rx_addr)
            begin
                alias_hit = 1'b1;
                alias_tgt = target_slave_identifier[i*7 +: 7];
            end
        end
    end

    i2c_bit_engine u_remote (
        .pclk(pclk),
        .presetn(presetn),
        .go(go_stop | go_op),
        .do_start(go_op & op_start_q),
        .do_stop(go_stop),
        .tx(op_tx_q),
        .nbits(go_stop ? BITS_NONE : op_n_q),
        .idle(eng_idle),
        .done(eng_done),
        .rx(eng_rx),
        .scl_in(rem_scl_in),
        .sda_in(rem_sda_in),
        .scl_oe(rem_scl_oe),
        .sda_oe(rem_sda_oe)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {scl_m, scl_s, scl_p, sda_m, sda_s, sda_p} <= 6'h3f;
            strap_m <= 2'h0;
            strap_s <= 2'h0;
            strap_cnt_q <= 2'h0;
            strap_taken_q <= 1'b0;
            strap_addr_q <= STRAP_ADDR0;
            own_addr_q <= STRAP_ADDR0;
            busy_q <= 1'b0;
            scl_hold_p <= 1'b0;
        end
        else
        begin
            {scl_m, scl_s, scl_p} <= {link.scl, scl_m, scl_s};
            {sda_m, sda_s, sda_p} <= {link.sda, sda_m, sda_s};
            strap_m <= address_strap_pin;
            strap_s <= strap_m;
            if (!strap_taken_q && strap_cnt_q == STRAP_SETTLE)
            begin
                strap_addr_q <= strap_dec;
                strap_taken_q <= 1'b1;
            end
            else if (!strap_taken_q)
                strap_cnt_q <= strap_cnt_q + 2'h1;
            own_addr_q <= id_select ? device_id : strap_addr_q;
            busy_q <= (st_q != S_IDLE) | ~eng_idle;
            scl_hold_p <= scl_hold_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= S_IDLE;
            bitcnt_q <= 4'h0;
            shift_q <= 8'h00;
            rdata_q <= 8'h00;
            {addr_byte_q, reading_q, fwd_q, host_ack_q, need_ack_q} <= 5'h00;
            {scl_hold_q, sda_drv_q} <= 2'h0;
            {remote_open_q, stop_pend_q, op_pend_q, op_busy_q, op_start_q} <= 5'h00;
            op_tx_q <= 9'h000;
            op_n_q <= 4'h0;
        end
        else
        begin
            if (go_op)
            begin
                op_pend_q <= 1'b0;
                op_busy_q <= 1'b1;
                if (op_start_q)
                    remote_open_q <= 1'b1;
            end
            else if (op_done)
                op_busy_q <= 1'b0;
            if (go_stop)
            begin
                stop_pend_q <= 1'b0;
                remote_open_q <= 1'b0;
            end
            if (stop_ev)
            begin
                st_q <= S_IDLE;
                sda_drv_q <= 1'b0;
                if (remote_open_q)
                    stop_pend_q <= 1'b1;
            end
            else if (start_ev)
            begin
                st_q <= S_RECV;
                bitcnt_q <= 4'h0;
                addr_byte_q <= 1'b1;
                sda_drv_q <= 1'b0;
            end
            else
            begin
                unique case (st_q)
                    S_IDLE: ;
                    S_RECV:
                        if (rise)
                        begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bitcnt_q <= bitcnt_q + 4'h1;
                        end
                        else if (fall && bitcnt_q == 4'h8)
                        begin
                            if (addr_byte_q)
                                reading_q <= shift_q[0];
                            if (addr_byte_q && is_own)
                            begin
                                fwd_q <= 1'b0;
                                sda_drv_q <= 1'b1;
                                rdata_q <= {own_addr_q, 1'b0};
                                st_q <= S_ACK;
                            end
                            else if (addr_byte_q && fwd_ok)
                            begin
                                fwd_q <= 1'b1;
                                scl_hold_q <= 1'b1;
                                op_pend_q <= 1'b1;
                                op_start_q <= 1'b1;
                                op_tx_q <= {fwd_addr, shift_q[0], 1'b1};
                                op_n_q <= BITS_BYTE_ACK;
                                st_q <= shift_q[0] ? S_HA : S_HW;
                            end
                            else if (addr_byte_q)
                                st_q <= S_ACK;
                            else if (fwd_q)
                            begin
                                scl_hold_q <= 1'b1;
                                op_pend_q <= 1'b1;
                                op_start_q <= 1'b0;
                                op_tx_q <= {shift_q, 1'b1};
                                op_n_q <= BITS_BYTE_ACK;
                                st_q <= S_HW;
                            end
                            else
                            begin
                                sda_drv_q <= 1'b1;
                                st_q <= S_ACK;
                            end
                        end
                    S_ACK:
                        if (fall)
                        begin
                            bitcnt_q <= 4'h0;
                            addr_byte_q <= 1'b0;
                            sda_drv_q <= sda_drv_q & reading_q & ~rdata_q[7];
                            if (!sda_drv_q)
                                st_q <= S_IDLE;
                            else
                                st_q <= reading_q ? S_SEND : S_RECV;
                        end
                    S_SEND:
                        if (rise)
                        begin
                            if (bitcnt_q == 4'h8)
                                host_ack_q <= ~sda_s;
                            bitcnt_q <= bitcnt_q + 4'h1;
                        end
                        else if (fall && bitcnt_q < 4'h8)
                            sda_drv_q <= ~rdata_q[3'h7 - bitcnt_q[2:0]];
                        else if (fall && bitcnt_q == 4'h8)
                            sda_drv_q <= 1'b0;
                        else if (fall)
                        begin
                            bitcnt_q <= 4'h0;
                            if (fwd_q)
                            begin
                                op_pend_q <= 1'b1;
                                op_start_q <= 1'b0;
                                op_tx_q <= {~host_ack_q, 8'hff};
                                op_n_q <= host_ack_q ? BITS_BYTE_ACK : BITS_ACK;
                            end
                            if (!host_ack_q)
                                st_q <= S_IDLE;
                            else if (fwd_q)
                            begin
                                scl_hold_q <= 1'b1;
                                need_ack_q <= 1'b0;
                                st_q <= S_HR;
                            end
                            else
                                sda_drv_q <= ~rdata_q[7];
                        end
                    S_HW:
                        if (op_done)
                        begin
                            scl_hold_q <= 1'b0;
                            sda_drv_q <= ~eng_rx[0];
                            st_q <= S_ACK;
                        end
                    S_HA:
                        if (op_done && !eng_rx[0])
                        begin
                            op_pend_q <= 1'b1;
                            op_start_q <= 1'b0;
                            op_tx_q <= TX_READ;
                            op_n_q <= BITS_BYTE;
                            need_ack_q <= 1'b1;
                            st_q <= S_HR;
                        end
                        else if (op_done)
                        begin
                            scl_hold_q <= 1'b0;
                            st_q <= S_ACK;
                        end
                    S_HR:
                        if (op_done)
                        begin
                            scl_hold_q <= 1'b0;
                            rdata_q <= eng_rx[7:0];
                            need_ack_q <= 1'b0;
                            sda_drv_q <= need_ack_q | ~eng_rx[7];
                            st_q <= need_ack_q ? S_ACK : S_SEND;
                        end
                    default: st_q <= S_IDLE;
                endcase
            end
        end
    end
endmodule

// ===== hdl/i2c_host_ctrl.sv
// Host end: APB-programmed I2C master that drives the bridge link
module i2c_host_ctrl
    import i2c_bridge_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link
    i2c_link_if.host link
);
    logic [12:0] cmd_q;
    logic [7:0] rxd_q;
    logic nack_q;
    logic eng_idle, eng_done;
    logic [8:0] eng_rx;

    wire acc = psel & penable;
    wire hit_cmd = (paddr == REG_CMD);
    wire hit_st = (paddr == REG_STATUS);
    wire busy = ~eng_idle;
    wire refuse = acc & pwrite & hit_cmd & busy;
    wire go = acc & pwrite & hit_cmd & ~busy;
    wire rd_cmd = pwdata[CMD_READ_BIT];
    wire [8:0] go_tx = rd_cmd ? {8'hff, pwdata[CMD_NACK_BIT]} : {pwdata[7:0], 1'b1};
    wire [3:0] go_n = pwdata[CMD_SKIP_BIT] ? BITS_NONE : BITS_BYTE_ACK;
    wire [31:0] st_word = {16'h0000, rxd_q, 6'h00, nack_q, busy};

    assign pready = 1'b1;
    assign pslverr = acc & ((~hit_cmd & ~hit_st) | refuse);
    assign prdata = (acc & ~pwrite & hit_st) ? st_word :
                    (acc & ~pwrite & hit_cmd) ? {19'h00000, cmd_q} : 32'h0000_0000;
    assign link.host_scl_out = 1'b0;
    assign link.host_sda_out = 1'b0;

    i2c_bit_engine u_master (
        .pclk(pclk),
        .presetn(presetn),
        .go(go),
        .do_start(pwdata[CMD_START_BIT]),
        .do_stop(pwdata[CMD_STOP_BIT]),
        .tx(go_tx),
        .nbits(go_n),
        .idle(eng_idle),
        .done(eng_done),
        .rx(eng_rx),
        .scl_in(link.scl),
        .sda_in(link.sda),
        .scl_oe(link.host_scl_oe),
        .sda_oe(link.host_sda_oe)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_q <= 13'h0000;
            rxd_q <= 8'h00;
            nack_q <= 1'b0;
        end
        else
        begin
            if (go)
                cmd_q <= pwdata[12:0];
            if (eng_done)
            begin
                rxd_q <= eng_rx[8:1];
                nack_q <= eng_rx[0];
            end
        end
    end
endmodule

// ===== dv/i2c_bridge_checker.sv
// Checker of the host-to-bridge I2C link
module i2c_bridge_checker
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    no_clk_gen_a: assert property (
        $rose(dev_scl_oe) |-> !$past(scl)) else $error("bridge pulled a high scl");
    stretch_pos_a: assert property (
        $rose(dev_scl_oe) |-> !dev_sda_oe) else $error("stretch with sda held");
    host_wait_a: assert property (
        !host_scl_oe && !scl |=> !host_scl_oe) else $error("host ignored stretch");
    scl_high_a: assert property (
        $rose(scl) |-> scl[*6]) else $error("scl high too short");
    scl_low_a: assert property (
        $fell(scl) |-> !scl[*8]) else $error("scl low too short");
    start_src_a: assert property (
        $fell(sda) && scl |-> host_sda_oe) else $error("start not from host");
    stop_src_a: assert property (
        $rose(sda) && scl |-> $past(host_sda_oe)) else $error("stop not from host");
    slave_sda_a: assert property (
        $changed(dev_sda_oe) |-> !scl) else $error("bridge moved sda in scl high");
    cover property ($rose(dev_scl_oe));
    cover property ($fell(sda) && scl);
    cover property ($rose(sda) && scl);
endmodule

// ===== dv/tb_i2c_control_bridge_addressing.sv
// Bench joining the host controller and the bridge over the I2C link
module tb_i2c_control_bridge_addressing
    import i2c_bridge_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] TBL [4] = '{STRAP_ADDR0, STRAP_ADDR1, STRAP_ADDR2, STRAP_ADDR3};
    logic pclk, presetn, psel, penable, pwrite, mark, pready, id_sel, pt_en, disp, perr, rerr, bbusy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [1:0] strap;
    logic [6:0] dev_id, own, ra;
    logic [7:0] av;
    logic [55:0] aid, tid;
    logic [9:0] rsh;
    logic [63:0] exp_q[$], exp_w;
    wire logic rem_scl_oe, rem_sda_oe;
    wire logic rscl = ~rem_scl_oe;
    wire logic rsda = ~rem_sda_oe;
    int fails = 0, compares = 0, rcnt = 0, n;
    i2c_link_if link ();
    i2c_host_ctrl i_i2c_host_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(perr), .link(link.host));
    i2c_bridge_dev i_i2c_bridge_dev (.pclk(pclk), .presetn(presetn), .link(link.dev),
        .rem_scl_in(rscl), .rem_scl_out(), .rem_scl_oe(rem_scl_oe), .rem_sda_in(rsda),
        .rem_sda_out(), .rem_sda_oe(rem_sda_oe), .address_strap_pin(strap),
        .id_select(id_sel), .device_id(dev_id), .pass_through_en(pt_en),
        .display_mode(disp), .alias_valid(av), .alias_id(aid),
        .target_slave_identifier(tid), .own_addr(own), .bridge_busy(bbusy));
    i2c_bridge_checker i_i2c_bridge_checker (.pclk(pclk), .presetn(presetn),
        .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
        .dev_scl_oe(link.dev_scl_oe), .dev_sda_oe(link.dev_sda_oe),
        .scl(link.scl), .sda(link.sda));
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Remote bus watcher: address bits and start count
    always @(posedge rscl) rsh <= {rsh[8:0], rsda};
    always @(negedge rsda) if (rscl) rcnt++;
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x)
        begin
            fails++;
            $display("FAIL t=%0t seen %h exp %h", $time, s, x);
        end
    endtask
    always @(posedge pclk)
        if (psel && penable && pready && mark)
        begin
            exp_w = exp_q.pop_front();
            chk(prdata & exp_w[63:32], exp_w[31:0]);
        end
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic m);
        @(posedge pclk);
        {psel, paddr, pwrite, pwdata, mark} <= {1'b1, a, w, d, m};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        rerr = perr;
        {psel, penable, mark} <= 3'h0;
    endtask
    task automatic rdx(input logic [11:0] a, input logic [31:0] msk, input logic [31:0] v);
        exp_q.push_back({msk, v});
        apb(a, 1'b0, 32'h0000_0000, 1'b1);
    endtask
    task automatic idle();
        do apb(REG_STATUS, 1'b0, 32'h0000_0000, 1'b0); while (rdv[ST_BUSY_BIT] !== 1'b0);
    endtask
    task automatic xfer(input logic [6:0] a, input logic nk, input logic fw, input logic [6:0] t);
        n = rcnt;
        idle();
        apb(REG_CMD, 1'b1, {23'h0, 1'b1, a, 1'b0}, 1'b0);
        idle();
        rdx(REG_STATUS, 32'h0000_0002, {30'h0, nk, 1'b0});
        apb(REG_CMD, 1'b1, 32'h0000_1200, 1'b0);
        idle();
        while (bbusy) @(posedge pclk);
        chk(32'(rcnt - n), 32'(fw));
        if (fw)
            chk(32'(rsh), 32'({t, 3'b010}));
    endtask
    task automatic close_out();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #6_000_000;
        fails++;
        close_out();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, mark, id_sel, pt_en, disp, paddr, pwdata} = '0;
        {strap, dev_id, av, aid, tid} = '0;
        void'($urandom(51320));
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk);
            {presetn, strap} <= {1'b0, 2'(i)};
            repeat (4) @(posedge pclk);
            presetn <= 1'b1;
            repeat (12) @(posedge pclk);
            chk(32'(own), 32'(TBL[i]));
        end
        strap <= 2'($urandom % 3);
        ra <= 7'h20 | 7'($urandom % 16);
        dev_id <= 7'h30 | 7'($urandom % 16);
        repeat (8) @(posedge pclk);
        chk(32'(own), 32'(STRAP_ADDR3));
        xfer(STRAP_ADDR3, 1'b0, 1'b0, 7'h00);
        apb(REG_CMD, 1'b1, {23'h0, 1'b1, STRAP_ADDR3, 1'b1}, 1'b0);
        idle();
        apb(REG_CMD, 1'b1, 32'h0000_0c00, 1'b0);
        idle();
        rdx(REG_STATUS, 32'h0000_ff02, {16'h0, STRAP_ADDR3, 9'h002});
        apb(REG_CMD, 1'b1, 32'h0000_1200, 1'b0);
        id_sel <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(32'(own), 32'(dev_id));
        xfer(dev_id, 1'b0, 1'b0, 7'h00);
        id_sel <= 1'b0;
        rdx(12'h008, 32'hffff_ffff, 32'h0000_0000);
        chk(32'(rerr), 32'h0000_0001);
        xfer(ra, 1'b1, 1'b0, 7'h00);
        pt_en <= 1'b1;
        xfer(ra, 1'b1, 1'b1, ra);
        pt_en <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            {disp, av} <= {i == 7, 8'(1) << i};
            {aid, tid} <= {56'h52 << (7 * i), 56'h50 << (7 * i)};
            xfer(7'h52, 1'b1, i != 7, 7'h50);
        end
        close_out();
    end
endmodule
